// ==== rtl/sep_pkg.sv ====
/*
 * Shared constants for the serial EEPROM protection and pin control block.
 * Assumes a 100 MHz system clock that oversamples the serial link pins.
 */
package sep_pkg;
    // ************************************************************
    // Instruction codes, upper nibble zero, bit 3 is don't care.
    // ************************************************************
    localparam logic [7:0] SEP_OP_MASK = 8'hF7;
    localparam logic [7:0] SEP_OP_READ = 8'h03;
    localparam logic [7:0] SEP_OP_WRITE = 8'h02;
    localparam logic [7:0] SEP_OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] SEP_OP_LATCH_SET = 8'h06;
    localparam logic [7:0] SEP_OP_STATUS_RD = 8'h05;
    localparam logic [7:0] SEP_OP_STATUS_WR = 8'h01;
    // ************************************************************
    // Status byte layout and reset values.
    // ************************************************************
    localparam int SEP_SR_BUSY = 0;
    localparam int SEP_SR_LATCH = 1;
    localparam int SEP_SR_BP_LO = 2;
    localparam int SEP_SR_BP_HI = 3;
    localparam logic [1:0] SEP_BP_RESET = 2'h0;
    // Pin sampler reset matches the idle bus, so no false edge follows reset.
    localparam logic [4:0] SEP_PIN_IDLE = 5'h13;
    localparam logic [7:0] SEP_ADDR_QUARTER = 8'hC0;
    localparam logic [7:0] SEP_ADDR_HALF = 8'h80;
    localparam logic [3:0] SEP_PAGE_MASK = 4'hF;
    // ************************************************************
    // Timing.
    // ************************************************************
    localparam int SEP_CLK_MHZ = 100;
    localparam int SEP_TWC_US = 5000;
    localparam int SEP_TWC_CYC = SEP_TWC_US * SEP_CLK_MHZ;
    localparam int SEP_FIFO_W = 16;
    localparam int SEP_FIFO_D = 8;
    typedef enum logic [2:0]
    {
        SEP_ST_STANDBY = 3'b000,
        SEP_ST_OPCODE = 3'b001,
        SEP_ST_ADDR = 3'b010,
        SEP_ST_DATA = 3'b011,
        SEP_ST_SRDATA = 3'b100,
        SEP_ST_OUT = 3'b101,
        SEP_ST_IGNORE = 3'b110
    } sep_state_e;
endpackage

// ==== rtl/sep_fifo.sv ====
/*
 * Synchronous FIFO holding address and data pairs of a page write.
 * Assumes one clock and a synchronous active high reset.
 */
`timescale 1ns/1ps
module sep_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_o = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_sys_i)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i || flush_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ==== rtl/sep_ctrl.sv ====
/*
 * Serial interface, write enable latch, block protection and write cycle
 * control of a 256 byte serial EEPROM. The array itself lives outside;
 * this block issues byte program requests and reads bytes back from it.
 * Assumes all pins are asynchronous to clk_sys_i and that the serial
 * clock is much slower than clk_sys_i.
 */
`timescale 1ns/1ps
module sep_ctrl
    import sep_pkg::*;
#(
    parameter int TWC_CYCLES = SEP_TWC_CYC
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    output logic so_o,
    output logic so_oe_o,
    output logic mem_rd_o,
    output logic [7:0] mem_rd_addr_o,
    input wire logic [7:0] mem_rd_data_i,
    output logic mem_wr_o,
    output logic [7:0] mem_wr_addr_o,
    output logic [7:0] mem_wr_data_o,
    output logic [1:0] block_protect_o,
    output logic write_enable_latch_o,
    output logic write_busy_flag_o
);
    // ************************************************************
    // Pin synchronisers.
    // ************************************************************
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic [4:0] pin_d;
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            pin_s1 <= SEP_PIN_IDLE;
            pin_s2 <= SEP_PIN_IDLE;
            pin_d <= SEP_PIN_IDLE;
        end
        else
        begin
            pin_s1 <= {cs_n_i, sck_i, si_i, hold_n_i, wp_n_i};
            pin_s2 <= pin_s1;
            pin_d <= pin_s2;
        end
    end

    assign {cs_n, sck, si, hold_n, wp_n} = pin_s2;

    // ************************************************************
    // Edge detection and pause tracking.
    // ************************************************************
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;
    logic paused;
    logic active;

    assign sck_rise = sck && !pin_d[3];
    assign sck_fall = !sck && pin_d[3];
    assign cs_rise = cs_n && !pin_d[4];
    assign cs_fall = !cs_n && pin_d[4];

    // Pause enters only with the clock low, or at the next falling edge;
    // it leaves when the pause input is high while the clock is low, or when chip select goes high.
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i || cs_n)
        begin
            paused <= 1'b0;
        end
        else if (!paused && !hold_n && !sck && active)
        begin
            paused <= 1'b1;
        end
        else if (paused && hold_n && !sck)
        begin
            paused <= 1'b0;
        end
    end

    // ************************************************************
    // Serial sequence engine.
    // ************************************************************
    sep_state_e state;
    logic [7:0] shift_in;
    logic [2:0] bit_cnt;
    logic [7:0] opcode;
    logic [7:0] addr;
    logic [7:0] out_byte;
    logic [1:0] bp_new;
    logic byte_done;
    logic sr_pending;
    logic [1:0] block_protect;
    logic latch;
    logic busy;
    logic [4:0] page_cnt;
    logic seq_ok;
    logic take_clk;
    logic [7:0] next_shift;

    function automatic logic op_is(input logic [7:0] op, input logic [7:0] c);
        op_is = ((op & SEP_OP_MASK) == c);
    endfunction

    function automatic logic addr_protected(input logic [1:0] bp,
                                            input logic [7:0] a);
        case (bp)
            2'b00: addr_protected = 1'b0;
            2'b01: addr_protected = (a >= SEP_ADDR_QUARTER);
            2'b10: addr_protected = (a >= SEP_ADDR_HALF);
            default: addr_protected = 1'b1;
        endcase
    endfunction

    assign take_clk = active && !paused;
    assign next_shift = {shift_in[6:0], si};
    assign byte_done = take_clk && sck_rise && (bit_cnt == 3'd7);

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            active <= 1'b0;
        end
        else if (cs_n)
        begin
            active <= 1'b0;
        end
        else if (cs_fall)
        begin
            active <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i || !active)
        begin
            shift_in <= 8'h00;
            bit_cnt <= 3'd0;
        end
        else if (take_clk && sck_rise)
        begin
            shift_in <= next_shift;
            bit_cnt <= bit_cnt + 3'd1;
        end
    end

    // Page bytes are queued in the FIFO; the writer drains it only
    // once the sequence has been closed correctly.
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [15:0] fifo_out_data;
    logic fifo_flush;

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i || !active)
        begin
            state <= SEP_ST_OPCODE;
            opcode <= 8'h00;
            addr <= 8'h00;
            bp_new <= SEP_BP_RESET;
            seq_ok <= 1'b0;
            page_cnt <= 5'd0;
        end
        else if (byte_done)
        begin
            case (state)
                SEP_ST_OPCODE:
                begin
                    opcode <= next_shift;
                    seq_ok <= op_is(next_shift, SEP_OP_LATCH_SET)
                        || op_is(next_shift, SEP_OP_LATCH_CLR);
                    if (op_is(next_shift, SEP_OP_READ)
                        || op_is(next_shift, SEP_OP_WRITE))
                    begin
                        state <= SEP_ST_ADDR;
                    end
                    else if (op_is(next_shift, SEP_OP_STATUS_WR))
                    begin
                        state <= SEP_ST_SRDATA;
                    end
                    else if (op_is(next_shift, SEP_OP_STATUS_RD))
                    begin
                        state <= SEP_ST_OUT;
                    end
                    else
                    begin
                        state <= SEP_ST_IGNORE;
                    end
                end
                SEP_ST_ADDR:
                begin
                    addr <= next_shift;
                    seq_ok <= 1'b0;
                    state <= op_is(opcode, SEP_OP_READ) ? SEP_ST_OUT
                        : SEP_ST_DATA;
                end
                SEP_ST_DATA:
                begin
                    seq_ok <= 1'b1;
                    addr <= {addr[7:4], addr[3:0] + 4'd1};
                    if (page_cnt != 5'd16)
                    begin
                        page_cnt <= page_cnt + 5'd1;
                    end
                end
                SEP_ST_SRDATA:
                begin
                    bp_new <= next_shift[SEP_SR_BP_HI:SEP_SR_BP_LO];
                    seq_ok <= 1'b1;
                    state <= SEP_ST_IGNORE;
                end
                SEP_ST_OUT:
                begin
                    addr <= addr + 8'd1;
                end
                default:
                begin
                    seq_ok <= 1'b0;
                end
            endcase
        end
        else if (take_clk && sck_rise && bit_cnt == 3'd0)
        begin
            seq_ok <= (state == SEP_ST_OPCODE) ? 1'b0 : seq_ok & 1'b0;
        end
    end

    // Bytes beyond 16 are dropped; nothing is queued during a write cycle,
    // since the drain would otherwise program them at once.
    assign fifo_in_valid = byte_done && state == SEP_ST_DATA
        && page_cnt != 5'd16 && !busy;
    assign fifo_flush = cs_fall;

    // ************************************************************
    // Write cycle timer and latch.
    // ************************************************************
    logic [$clog2(TWC_CYCLES+1)-1:0] twc_cnt;
    logic start_array;
    logic start_status;
    logic allowed;

    assign allowed = wp_n && latch && !busy;
    assign start_array = cs_rise && seq_ok && allowed
        && op_is(opcode, SEP_OP_WRITE);
    assign start_status = cs_rise && seq_ok && allowed
        && op_is(opcode, SEP_OP_STATUS_WR);

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            busy <= 1'b0;
            twc_cnt <= '0;
            sr_pending <= 1'b0;
        end
        else if (start_array || start_status)
        begin
            busy <= 1'b1;
            twc_cnt <= '0;
            sr_pending <= start_status;
        end
        else if (busy)
        begin
            if (twc_cnt == ($bits(twc_cnt))'(TWC_CYCLES - 1))
            begin
                busy <= 1'b0;
            end
            twc_cnt <= twc_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            block_protect <= SEP_BP_RESET;
        end
        else if (start_status)
        begin
            block_protect <= bp_new;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            latch <= 1'b0;
        end
        else if (!wp_n)
        begin
            latch <= 1'b0;
        end
        else if (busy && twc_cnt == ($bits(twc_cnt))'(TWC_CYCLES - 1))
        begin
            latch <= 1'b0;
        end
        else if (cs_rise && seq_ok && !busy)
        begin
            if (op_is(opcode, SEP_OP_LATCH_SET))
            begin
                latch <= 1'b1;
            end
            else if (op_is(opcode, SEP_OP_LATCH_CLR))
            begin
                latch <= 1'b0;
            end
        end
    end

    // Queued bytes go to the array during the cycle; protected ones drop.
    assign fifo_out_ready = busy && !sr_pending;

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            mem_wr_o <= 1'b0;
            mem_wr_addr_o <= 8'h00;
            mem_wr_data_o <= 8'h00;
        end
        else
        begin
            mem_wr_o <= fifo_out_valid && fifo_out_ready
                && !addr_protected(block_protect, fifo_out_data[15:8]);
            mem_wr_addr_o <= fifo_out_data[15:8];
            mem_wr_data_o <= fifo_out_data[7:0];
        end
    end

    sep_fifo #(
        .WIDTH(SEP_FIFO_W),
        .DEPTH(SEP_FIFO_D * 2)
    ) sep_fifo_inst (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .flush_i(fifo_flush && !busy),
        .in_valid_i(fifo_in_valid),
        .in_ready_o(fifo_in_ready),
        .in_data_i({addr, next_shift}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // ************************************************************
    // Read path and serial output.
    // ************************************************************
    logic so_bit;

    assign mem_rd_o = active && state == SEP_ST_OUT && !busy
        && !op_is(opcode, SEP_OP_STATUS_RD);
    assign mem_rd_addr_o = addr;

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i || !active)
        begin
            out_byte <= 8'h00;
            so_bit <= 1'b0;
        end
        else if (take_clk && sck_fall && state == SEP_ST_OUT)
        begin
            if (bit_cnt == 3'd0)
            begin
                out_byte <= op_is(opcode, SEP_OP_STATUS_RD)
                    ? {4'h0, block_protect, latch, busy} : mem_rd_data_i;
                so_bit <= op_is(opcode, SEP_OP_STATUS_RD) ? 1'b0
                    : mem_rd_data_i[7];
            end
            else
            begin
                so_bit <= out_byte[3'd7 - bit_cnt];
            end
        end
    end

    assign so_o = so_bit;
    assign so_oe_o = active && !cs_n && hold_n && !paused
        && state == SEP_ST_OUT;
    assign block_protect_o = block_protect;
    assign write_enable_latch_o = latch;
    assign write_busy_flag_o = busy;
endmodule

// ==== tb/sep_ctrl_asserts.sv ====
/*
 * Concurrent checks on the ports of sep_ctrl.
 * Assumes it is bound to sep_ctrl and sees only its top-level ports.
 */
`timescale 1ns/1ps
module sep_ctrl_asserts #(
    parameter int TWC_CYCLES = 50
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic cs_n_i,
    input wire logic hold_n_i,
    input wire logic wp_n_i,
    input wire logic so_oe_o,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic [7:0] mem_wr_addr_o,
    input wire logic [1:0] block_protect_o,
    input wire logic write_enable_latch_o,
    input wire logic write_busy_flag_o
);
    logic [31:0] busy_cnt;
    logic prot;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);
    // ****************************************************************
    // Helper logic: busy length counter and protected-address decode.
    // ****************************************************************
    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i || !write_busy_flag_o)
            busy_cnt <= '0;
        else
            busy_cnt <= busy_cnt + 32'd1;
    end
    assign prot = (block_protect_o == 2'b11)
        || (block_protect_o == 2'b10 && mem_wr_addr_o[7])
        || (block_protect_o == 2'b01 && mem_wr_addr_o[7:6] == 2'b11);
    a_oe_deselect: assert property (cs_n_i [*5] |-> !so_oe_o)
        else $error("output driven while deselected");
    a_oe_pause: assert property (!hold_n_i [*5] |-> !so_oe_o)
        else $error("output driven while paused");
    a_wp_latch: assert property (
        !wp_n_i [*5] |-> !write_enable_latch_o)
        else $error("latch set while write protect low");
    a_wp_nostart: assert property (
        !wp_n_i [*8] |-> !$rose(write_busy_flag_o))
        else $error("write cycle started under write protect");
    a_busy_len: assert property (
        $fell(write_busy_flag_o) |-> busy_cnt == TWC_CYCLES)
        else $error("write cycle length wrong");
    a_latch_done: assert property (
        $fell(write_busy_flag_o) |-> !write_enable_latch_o)
        else $error("latch still set after write cycle");
    a_bp_change: assert property (
        $changed(block_protect_o)
        |-> write_busy_flag_o || $past(write_busy_flag_o))
        else $error("block bits changed outside a status write");
    a_cs_start: assert property (
        $rose(write_busy_flag_o) |-> cs_n_i && $past(cs_n_i, 2))
        else $error("write cycle started with chip select low");
    a_prot_block: assert property (mem_wr_o |-> !prot)
        else $error("protected address programmed");
    a_rd_busy: assert property (mem_rd_o |-> !write_busy_flag_o)
        else $error("array read during write cycle");
    c_write: cover property ($rose(write_busy_flag_o));
    c_pause: cover property ($fell(hold_n_i) && !cs_n_i);
    c_read: cover property (mem_rd_o);
endmodule
bind sep_ctrl sep_ctrl_asserts #(.TWC_CYCLES(TWC_CYCLES)) sep_ctrl_asserts_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n_i),
    .hold_n_i(hold_n_i), .wp_n_i(wp_n_i), .so_oe_o(so_oe_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wr_addr_o(mem_wr_addr_o),
    .block_protect_o(block_protect_o),
    .write_enable_latch_o(write_enable_latch_o),
    .write_busy_flag_o(write_busy_flag_o));

// ==== tb/sep_host_model.sv ====
/*
 * Serial host model: mode 0 frames with an optional pause in mid-frame.
 * Assumes the system clock is 100 MHz; the serial clock period is 160 ns.
 */
`timescale 1ns/1ps
module sep_host_model (
    input wire logic clk_sys_i,
    input wire logic so_i,
    input wire logic so_oe_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o,
    output logic hold_n_o
);
    initial
    begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
        hold_n_o = 1'b1;
    end
    // ****************************************************************
    // Frame tasks; the serial clock stands low between frames.
    // ****************************************************************
    task automatic half();
        repeat (8) @(negedge clk_sys_i);
    endtask
    // Pause with clock low, wiggle the lines, resume with clock low.
    task automatic pause();
        hold_n_o <= 1'b0;
        half();
        repeat (2)
        begin
            sck_o <= ~sck_o;
            si_o <= ~si_o;
            half();
        end
        hold_n_o <= 1'b1;
        half();
    endtask
    task automatic xfer(input logic [31:0] data, input int nbits,
                        input int pause_at, output logic [31:0] rx);
        rx = '0;
        @(negedge clk_sys_i);
        cs_n_o <= 1'b0;
        half();
        for (int i = nbits - 1; i >= 0; i--)
        begin
            si_o <= data[i];
            if (i == pause_at)
                pause();
            half();
            rx = {rx[30:0], so_oe_i ? so_i : 1'bx};
            sck_o <= 1'b1;
            half();
            sck_o <= 1'b0;
        end
        half();
        cs_n_o <= 1'b1;
        // A released data line must not keep its last value.
        si_o <= ~si_o;
        repeat (20) @(negedge clk_sys_i);
    endtask
endmodule

// ==== tb/tb_sep_ctrl.sv ====
/*
 * Self-checking bench for sep_ctrl driven through a serial host model.
 * Assumes the array answers reads with its address xor 5Ah.
 */
`timescale 1ns/1ps
`define CHK(g, e) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("wrong value at %0t ns: compare mismatch", $time); \
        end \
    end
module tb_sep_ctrl;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic wp_n_i = 1'b1;
    logic cs_n, sck, si, hold_n, so_o, so_oe_o, mem_rd_o, mem_wr_o;
    logic [7:0] mem_rd_addr_o, mem_wr_addr_o, mem_wr_data_o;
    logic [1:0] block_protect_o;
    logic write_enable_latch_o, write_busy_flag_o;
    logic [31:0] rx;
    logic [15:0] last_wr;
    logic [7:0] addrs [3] = '{8'h00, 8'h80, 8'hC0};
    int fail_count = 0;
    int cmp_count = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;
    int n0;
    initial
    begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    sep_ctrl #(.TWC_CYCLES(1000)) sep_ctrl_inst (.clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .hold_n_i(hold_n), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_o(so_oe_o),
        .mem_rd_o(mem_rd_o), .mem_rd_addr_o(mem_rd_addr_o),
        .mem_rd_data_i(mem_rd_addr_o ^ 8'h5A), .mem_wr_o(mem_wr_o),
        .mem_wr_addr_o(mem_wr_addr_o), .mem_wr_data_o(mem_wr_data_o),
        .block_protect_o(block_protect_o),
        .write_enable_latch_o(write_enable_latch_o),
        .write_busy_flag_o(write_busy_flag_o));
    sep_host_model sep_host_model_inst (.clk_sys_i(clk_sys_i), .so_i(so_o),
        .so_oe_i(so_oe_o), .cs_n_o(cs_n), .sck_o(sck), .si_o(si),
        .hold_n_o(hold_n));
    always @(posedge clk_sys_i)
    begin
        if (mem_wr_o)
        begin
            wr_cnt++;
            last_wr = {mem_wr_addr_o, mem_wr_data_o};
        end
        if (mem_rd_o)
            rd_cnt++;
    end
    // ****************************************************************
    // Access tasks and the closing report.
    // ****************************************************************
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic xf(input logic [31:0] d, input int n);
        sep_host_model_inst.xfer(d, n, -1, rx);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (write_busy_flag_o !== 1'b0 && n < 1500)
        begin
            @(negedge clk_sys_i);
            n++;
        end
        if (n == 1500)
        begin
            fail_count++;
            $display("wrong value at %0t ns: busy wait timed out", $time);
            complete_run();
        end
    endtask
    function automatic bit prot(input int k, input logic [7:0] a);
        return k == 3 || (k == 2 && a[7]) || (k == 1 && a[7:6] == 2'b11);
    endfunction
    initial
    begin
        repeat (10) @(negedge clk_sys_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(negedge clk_sys_i);
        `CHK(write_enable_latch_o, 1'b0)
        `CHK(so_oe_o, 1'b0)
        xf(32'h010C, 16);
        `CHK(write_busy_flag_o, 1'b0)
        xf(32'h06, 8);
        `CHK(write_enable_latch_o, 1'b1)
        xf(32'h04, 8);
        `CHK(write_enable_latch_o, 1'b0)
        xf(32'h06, 8);
        xf(32'h0086, 15);
        `CHK(write_busy_flag_o, 1'b0)
        for (int k = 0; k < 4; k++)
        begin
            xf(32'h06, 8);
            sep_host_model_inst.xfer({24'h01, 4'h0, k[1:0], 2'b00}, 16,
                10, rx);
            `CHK(write_busy_flag_o, 1'b1)
            `CHK(block_protect_o, k[1:0])
            xf(32'h0500, 16);
            `CHK(rx[0], 1'b1)
            wait_idle();
            `CHK(write_enable_latch_o, 1'b0)
            xf(32'h0500, 16);
            `CHK(rx[7:0], {4'h0, k[1:0], 2'b00})
            foreach (addrs[j])
            begin
                n0 = wr_cnt;
                xf(32'h06, 8);
                xf({16'h02, addrs[j], 8'hA5}, 24);
                wait_idle();
                `CHK(wr_cnt - n0, prot(k, addrs[j]) ? 0 : 1)
                if (!prot(k, addrs[j]))
                    `CHK(last_wr, {addrs[j], 8'hA5})
            end
        end
        xf(32'h06, 8);
        xf(32'h0100, 16);
        wait_idle();
        xf(32'h06, 8);
        xf(32'h021033, 24);
        wp_n_i <= 1'b0;
        n0 = rd_cnt;
        xf(32'h031000, 24);
        xf(32'h021144, 24);
        `CHK(write_busy_flag_o, 1'b1)
        `CHK(rd_cnt - n0, 0)
        wait_idle();
        `CHK(last_wr, 16'h1033)
        xf(32'h06, 8);
        `CHK(write_enable_latch_o, 1'b0)
        xf(32'h021122, 24);
        `CHK(write_busy_flag_o, 1'b0)
        wp_n_i <= 1'b1;
        n0 = rd_cnt;
        xf(32'h033C00, 24);
        `CHK(rx[7:0], 8'h66)
        `CHK(rd_cnt > n0, 1'b1)
        `CHK(so_oe_o, 1'b0)
        complete_run();
    end
endmodule
